// ===== rtl/sct_pkg.sv
// Shared constants and types of the slave core transfer and accumulator engine.
// Assumes every user names items as sct_pkg::name; nothing is imported.
package sct_pkg;
  // Values after reset
  localparam int PC_RST = 0;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] PSW_RST = 8'h00;
  localparam logic [3:0] STS_RST = 4'h0;
  localparam logic FLAG_RST = 1'b0;

  // Field positions in the program status word and host status register, and the page number used by table reads
  localparam int PSW_CY = 7;
  localparam int PSW_AC = 6;
  localparam int PSW_F0 = 5;
  localparam int STS_LSB = 4;
  localparam int TBL_PAGE3 = 3;

  // Operation families by opcode[7:4], immediate forms have opcode[3:0] == 3
  localparam logic [3:0] FAM_ADDI = 4'h0;
  localparam logic [3:0] FAM_ADDCI = 4'h1;
  localparam logic [3:0] FAM_MOVI = 4'h2;
  localparam logic [3:0] FAM_OR = 4'h4;
  localparam logic [3:0] FAM_AND = 4'h5;
  localparam logic [3:0] FAM_ADD = 4'h6;
  localparam logic [3:0] FAM_ADD_WITH_CARRY = 4'h7;
  localparam logic [3:0] FAM_XOR = 4'hD;
  localparam logic [3:0] LO_IMM = 4'h3;

  // Register forms, matched on opcode[7:3]
  localparam logic [4:0] G5_MOV_A_R = 5'h1F;
  localparam logic [4:0] G5_MOV_R_A = 5'h15;
  localparam logic [4:0] G5_MOV_R_IMM = 5'h17;
  localparam logic [4:0] G5_XCH_R = 5'h05;
  localparam logic [4:0] G5_ADD_R = 5'h0D;

  // Indirect forms, matched on opcode[7:1]
  localparam logic [6:0] G7_MOV_A_M = 7'h78;
  localparam logic [6:0] G7_MOV_M_A = 7'h50;
  localparam logic [6:0] G7_MOV_M_IMM = 7'h58;
  localparam logic [6:0] G7_XCH_M = 7'h10;
  localparam logic [6:0] G7_NIBBLE_EXCHANGE_INDIRECT_M = 7'h18;

  // Whole opcodes
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_MOV_A_IMM = 8'h23;
  localparam logic [7:0] OP_TBL_CUR = 8'hA3;
  localparam logic [7:0] OP_TBL_PG3 = 8'hE3;
  localparam logic [7:0] OP_RD_PSW = 8'hC7;
  localparam logic [7:0] OP_WR_PSW = 8'hD7;
  localparam logic [7:0] OP_WR_STS = 8'h90;
  localparam logic [7:0] OP_CLR_C = 8'h97;
  localparam logic [7:0] OP_CPL_C = 8'hA7;
  localparam logic [7:0] OP_CLR_UF0 = 8'h85;
  localparam logic [7:0] OP_CPL_UF0 = 8'h95;
  localparam logic [7:0] OP_CLR_UF1 = 8'hA5;
  localparam logic [7:0] OP_CPL_UF1 = 8'hB5;
  localparam logic [7:0] OP_INC_A = 8'h17;
  localparam logic [7:0] OP_DEC_A = 8'h07;

  // Sequencer states, three per machine cycle
  typedef enum logic [5:0] {
    ST_FETCH = 6'h01,
    ST_DECODE = 6'h02,
    ST_EXEC = 6'h04,
    ST_FETCH2 = 6'h08,
    ST_LOAD2 = 6'h10,
    ST_EXEC2 = 6'h20
  } sct_state_t;

  typedef enum logic [2:0] {
    ALU_PASS = 3'h0,
    ALU_ADD = 3'h1,
    ALU_ADD_WITH_CARRY = 3'h2,
    ALU_AND = 3'h3,
    ALU_OR = 3'h4,
    ALU_XOR = 3'h5,
    ALU_INC = 3'h6,
    ALU_DEC = 3'h7
  } sct_alu_op_t;
endpackage

// ===== rtl/sct_mem_if.sv
// Port bundle between the core and its internal data memory.
// Assumes one clock; read data arrive one edge after the address.
`timescale 1ns/10ps
`default_nettype none
interface sct_mem_if #(
  parameter int AW = 8
);
  logic [AW-1:0] addr;
  logic we;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport core (output addr, output we, output wdata, input rdata);
  modport mem (input addr, input we, input wdata, output rdata);
endinterface
`default_nettype wire

// ===== rtl/sct_data_ram.sv
// Internal data memory, one port, registered read data.
// Assumes the core holds the address steady around a read-modify-write.
`timescale 1ns/10ps
`default_nettype none
module sct_data_ram #(
  parameter int AW = 8
) (
  input wire logic core_clk,
  sct_mem_if.mem bus
);
  logic [7:0] mem_ff [2**AW];
  logic [7:0] rdata_ff;

  // Read returns the old byte on a same-edge write, which exchanges rely on
  always_ff @(posedge core_clk) begin
    if (bus.we) begin
      mem_ff[bus.addr] <= bus.wdata;
    end
    rdata_ff <= mem_ff[bus.addr];
  end

  assign bus.rdata = rdata_ff;
endmodule // sct_data_ram
`default_nettype wire

// ===== rtl/sct_alu.sv
// Accumulator arithmetic and logic unit, purely combinational.
// Assumes the caller registers result and flags.
`timescale 1ns/10ps
`default_nettype none
module sct_alu (
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic carry_in,
  input wire sct_pkg::sct_alu_op_t op,
  output logic [7:0] result,
  output logic carry_out,
  output logic aux_carry
);
  logic cin;
  logic [8:0] sum;
  logic [4:0] low;

  // Full and low-nibble sums share one incoming carry
  always_comb begin
    cin = (op == sct_pkg::ALU_ADD_WITH_CARRY) ? carry_in : 1'b0;
    sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    carry_out = sum[8];
    aux_carry = low[4];
    unique case (op)
      sct_pkg::ALU_ADD, sct_pkg::ALU_ADD_WITH_CARRY: result = sum[7:0];
      sct_pkg::ALU_AND: result = a & b;
      sct_pkg::ALU_OR: result = a | b;
      sct_pkg::ALU_XOR: result = a ^ b;
      sct_pkg::ALU_INC: result = a + 8'h01;
      sct_pkg::ALU_DEC: result = a - 8'h01;
      sct_pkg::ALU_PASS: result = b;
    endcase
  end
endmodule // sct_alu
`default_nettype wire

// ===== rtl/sct_core.sv
// Slave core engine: transfers, table reads, flags and accumulator ALU ops.
// Assumes a synchronous program ROM outside: data valid the clock after prog_addr.
// Function
// - opcode 23 then a byte loads that byte into the accumulator, two cycles
// - opcode F8+r copies working register r into the accumulator
// - opcode A8+r copies the accumulator into working register r
// - opcode B8+r then a byte loads that byte into register r, two cycles
// - opcode 28+r swaps accumulator and working register r
// - opcode F0+r reads data memory at register 0/1 into the accumulator
// - A0+r writes accumulator, B0+r writes an immediate, to memory at register 0/1
// - opcode A3 loads accumulator from program memory, current page, offset accumulator
// - opcode E3 loads accumulator from program memory page 3, offset accumulator
// - opcode 20+r swaps accumulator with memory addressed by register 0/1
// - opcode 30+r swaps only low nibbles of accumulator and that memory byte
// - opcode C7 copies the status word into the accumulator
// - opcode D7 loads status word from accumulator, carry bit 7, aux bit 6
// - opcode 90 copies accumulator bits 7..4 into host status bits 7..4
// - 97/A7 clear/invert carry; 85/95 user flag zero; A5/B5 user flag one
// - 03, 68+r, 60+r add operand to accumulator without incoming carry
// - 13, 78+r, 70+r add operand plus carry to accumulator
// - 53, 58+r, 50+r AND operand into accumulator
// - 43, 48+r, 40+r OR operand into accumulator
// - D3, D8+r, D0+r exclusive-OR operand into accumulator
// - adds set carry and aux carry on overflow, else clear; sum kept
`timescale 1ns/10ps
`default_nettype none
module sct_core #(
  parameter int PC_W = 11,
  parameter int DM_AW = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  output logic [PC_W-1:0] prog_addr,
  input wire logic [7:0] prog_data,
  output logic [7:0] acc_value,
  output logic [7:0] psw_value,
  output logic user_flag_one,
  output logic [3:0] host_status_hi,
  output logic instr_done
);
  typedef struct packed {
    sct_pkg::sct_state_t st;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] paddr;
    logic [7:0] opcode;
    logic [7:0] operand;
    logic [7:0] acc;
    logic [7:0] program_status_word;
    logic f1;
    logic [3:0] sts_hi;
    logic [7:0][7:0] wreg;
    logic done;
  } sct_core_t;

  localparam sct_core_t CORE_RST = '{
    st: sct_pkg::ST_FETCH,
    pc: PC_W'(sct_pkg::PC_RST),
    paddr: PC_W'(sct_pkg::PC_RST),
    opcode: sct_pkg::BYTE_RST,
    operand: sct_pkg::BYTE_RST,
    acc: sct_pkg::BYTE_RST,
    program_status_word: sct_pkg::PSW_RST,
    f1: sct_pkg::FLAG_RST,
    sts_hi: sct_pkg::STS_RST,
    wreg: {8{sct_pkg::BYTE_RST}},
    done: sct_pkg::FLAG_RST
  };

  sct_core_t core_ff;
  sct_core_t nxt_core;

  logic [3:0] fam;
  logic [3:0] lo;
  logic [2:0] rsel;
  logic is_rf;
  logic is_im;
  logic is_tbl;
  logic is_imm2;
  logic two_cyc;
  logic retire;
  logic ram_we;
  logic [7:0] ram_wdata;
  logic [7:0] ind_ptr;
  logic [7:0] alu_b;
  logic [7:0] alu_res;
  logic alu_cy;
  logic alu_ac;
  sct_pkg::sct_alu_op_t alu_op;

  sct_mem_if #(.AW(DM_AW)) dmem_bus ();

  sct_data_ram #(.AW(DM_AW)) u_ram (
    .core_clk(core_clk),
    .bus(dmem_bus)
  );

  sct_alu u_alu (
    .a(core_ff.acc),
    .b(alu_b),
    .carry_in(core_ff.program_status_word[sct_pkg::PSW_CY]),
    .op(alu_op),
    .result(alu_res),
    .carry_out(alu_cy),
    .aux_carry(alu_ac)
  );

  // Pointer comes from the fresh opcode in decode so the byte is ready at execute
  assign ind_ptr = (core_ff.st == sct_pkg::ST_DECODE) ?
                   core_ff.wreg[{2'h0, prog_data[0]}] :
                   core_ff.wreg[{2'h0, core_ff.opcode[0]}];
  assign dmem_bus.addr = ind_ptr[DM_AW-1:0];
  assign dmem_bus.we = ram_we;
  assign dmem_bus.wdata = ram_wdata;

  // Opcode classes and ALU operand selection
  always_comb begin
    fam = core_ff.opcode[7:4];
    lo = core_ff.opcode[3:0];
    rsel = core_ff.opcode[2:0];
    is_rf = lo[3] | (lo[3:1] == 3'h0);
    is_im = (lo == sct_pkg::LO_IMM);
    is_tbl = (core_ff.opcode == sct_pkg::OP_TBL_CUR) ||
             (core_ff.opcode == sct_pkg::OP_TBL_PG3);
    is_imm2 = (is_im && (fam inside {sct_pkg::FAM_ADDI, sct_pkg::FAM_ADDCI,
                                     sct_pkg::FAM_MOVI, sct_pkg::FAM_OR,
                                     sct_pkg::FAM_AND, sct_pkg::FAM_XOR})) ||
              (core_ff.opcode[7:3] == sct_pkg::G5_MOV_R_IMM) ||
              (core_ff.opcode[7:1] == sct_pkg::G7_MOV_M_IMM);
    two_cyc = is_imm2 | is_tbl;
    // Immediate, register or indirect byte, picked by the low nibble
    if (is_im) begin
      alu_b = core_ff.operand;
    end else if (lo[3]) begin
      alu_b = core_ff.wreg[rsel];
    end else begin
      alu_b = dmem_bus.rdata;
    end
    alu_op = sct_pkg::ALU_PASS;
    case (fam)
      sct_pkg::FAM_ADDI: if (is_im) alu_op = sct_pkg::ALU_ADD;
      sct_pkg::FAM_ADDCI: if (is_im) alu_op = sct_pkg::ALU_ADD_WITH_CARRY;
      sct_pkg::FAM_ADD: if (is_rf) alu_op = sct_pkg::ALU_ADD;
      sct_pkg::FAM_ADD_WITH_CARRY: if (is_rf) alu_op = sct_pkg::ALU_ADD_WITH_CARRY;
      sct_pkg::FAM_AND: if (is_rf || is_im) alu_op = sct_pkg::ALU_AND;
      sct_pkg::FAM_OR: if (is_rf || is_im) alu_op = sct_pkg::ALU_OR;
      sct_pkg::FAM_XOR: if (is_rf || is_im) alu_op = sct_pkg::ALU_XOR;
      default: alu_op = sct_pkg::ALU_PASS;
    endcase
    if (core_ff.opcode == sct_pkg::OP_INC_A) begin
      alu_op = sct_pkg::ALU_INC;
    end
    if (core_ff.opcode == sct_pkg::OP_DEC_A) begin
      alu_op = sct_pkg::ALU_DEC;
    end
  end

  // Sequencer and instruction effects; each machine cycle is three states
  always_comb begin
    nxt_core = core_ff;
    nxt_core.done = 1'b0;
    ram_we = 1'b0;
    ram_wdata = core_ff.acc;
    retire = 1'b0;
    unique case (core_ff.st)
      sct_pkg::ST_FETCH: begin
        nxt_core.st = sct_pkg::ST_DECODE;
      end
      sct_pkg::ST_DECODE: begin
        nxt_core.opcode = prog_data;
        nxt_core.pc = core_ff.pc + PC_W'(1);
        nxt_core.st = sct_pkg::ST_EXEC;
      end
      sct_pkg::ST_EXEC: begin
        if (two_cyc) begin
          nxt_core.st = sct_pkg::ST_FETCH2;
          if (core_ff.opcode == sct_pkg::OP_TBL_CUR) begin
            nxt_core.paddr = {core_ff.pc[PC_W-1:8], core_ff.acc};
          end else if (core_ff.opcode == sct_pkg::OP_TBL_PG3) begin
            nxt_core.paddr = {(PC_W-8)'(sct_pkg::TBL_PAGE3), core_ff.acc};
          end else begin
            // Second byte of the instruction
            nxt_core.paddr = core_ff.pc;
            nxt_core.pc = core_ff.pc + PC_W'(1);
          end
        end else begin
          retire = 1'b1;
        end
      end
      sct_pkg::ST_FETCH2: begin
        nxt_core.st = sct_pkg::ST_LOAD2;
      end
      sct_pkg::ST_LOAD2: begin
        nxt_core.operand = prog_data;
        nxt_core.st = sct_pkg::ST_EXEC2;
      end
      sct_pkg::ST_EXEC2: begin
        retire = 1'b1;
      end
      default: begin
        // A broken one-hot code restarts at the fetch of the current address
        nxt_core.st = sct_pkg::ST_FETCH;
        nxt_core.paddr = core_ff.pc;
      end
    endcase

    if (retire) begin
      nxt_core.st = sct_pkg::ST_FETCH;
      nxt_core.paddr = nxt_core.pc;
      nxt_core.done = 1'b1;
      // Arithmetic and logic results
      if (alu_op != sct_pkg::ALU_PASS) begin
        nxt_core.acc = alu_res;
      end
      if (alu_op inside {sct_pkg::ALU_ADD, sct_pkg::ALU_ADD_WITH_CARRY}) begin
        nxt_core.program_status_word[sct_pkg::PSW_CY] = alu_cy;
        nxt_core.program_status_word[sct_pkg::PSW_AC] = alu_ac;
      end
      // Working register transfers
      case (core_ff.opcode[7:3])
        sct_pkg::G5_MOV_A_R: nxt_core.acc = core_ff.wreg[rsel];
        sct_pkg::G5_MOV_R_A: nxt_core.wreg[rsel] = core_ff.acc;
        sct_pkg::G5_MOV_R_IMM: nxt_core.wreg[rsel] = core_ff.operand;
        sct_pkg::G5_XCH_R: begin
          nxt_core.acc = core_ff.wreg[rsel];
          nxt_core.wreg[rsel] = core_ff.acc;
        end
        default: ;
      endcase
      // Indirect data memory transfers through register 0 or 1
      case (core_ff.opcode[7:1])
        sct_pkg::G7_MOV_A_M: nxt_core.acc = dmem_bus.rdata;
        sct_pkg::G7_MOV_M_A: ram_we = 1'b1;
        sct_pkg::G7_MOV_M_IMM: begin
          ram_we = 1'b1;
          ram_wdata = core_ff.operand;
        end
        sct_pkg::G7_XCH_M: begin
          nxt_core.acc = dmem_bus.rdata;
          ram_we = 1'b1;
        end
        sct_pkg::G7_NIBBLE_EXCHANGE_INDIRECT_M: begin
          // Upper nibbles of both bytes are kept in place
          nxt_core.acc = {core_ff.acc[7:4], dmem_bus.rdata[3:0]};
          ram_we = 1'b1;
          ram_wdata = {dmem_bus.rdata[7:4], core_ff.acc[3:0]};
        end
        default: ;
      endcase
      // Whole-opcode actions; anything unmatched retires with no change
      case (core_ff.opcode)
        sct_pkg::OP_MOV_A_IMM: nxt_core.acc = core_ff.operand;
        sct_pkg::OP_TBL_CUR: nxt_core.acc = core_ff.operand;
        sct_pkg::OP_TBL_PG3: nxt_core.acc = core_ff.operand;
        sct_pkg::OP_RD_PSW: nxt_core.acc = core_ff.program_status_word;
        sct_pkg::OP_WR_PSW: nxt_core.program_status_word = core_ff.acc;
        sct_pkg::OP_WR_STS: nxt_core.sts_hi = core_ff.acc[7:sct_pkg::STS_LSB];
        sct_pkg::OP_CLR_C: nxt_core.program_status_word[sct_pkg::PSW_CY] = 1'b0;
        sct_pkg::OP_CPL_C: nxt_core.program_status_word[sct_pkg::PSW_CY] = ~core_ff.program_status_word[sct_pkg::PSW_CY];
        sct_pkg::OP_CLR_UF0: nxt_core.program_status_word[sct_pkg::PSW_F0] = 1'b0;
        sct_pkg::OP_CPL_UF0: nxt_core.program_status_word[sct_pkg::PSW_F0] = ~core_ff.program_status_word[sct_pkg::PSW_F0];
        sct_pkg::OP_CLR_UF1: nxt_core.f1 = 1'b0;
        sct_pkg::OP_CPL_UF1: nxt_core.f1 = ~core_ff.f1;
        default: ;
      endcase
    end
  end

  // All core state in one register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_ff <= CORE_RST;
    end else begin
      core_ff <= nxt_core;
    end
  end

  assign prog_addr = core_ff.paddr;
  assign acc_value = core_ff.acc;
  assign psw_value = core_ff.program_status_word;
  assign user_flag_one = core_ff.f1;
  assign host_status_hi = core_ff.sts_hi;
  assign instr_done = core_ff.done;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_imm_load_acc :
  assert property ((core_ff.st == sct_pkg::ST_EXEC2) &&
                   (core_ff.opcode == sct_pkg::OP_MOV_A_IMM)
                   |=> instr_done && (acc_value == $past(core_ff.operand)))
    else $error("immediate byte did not reach the accumulator");

  a_reg_to_acc :
  assert property ((core_ff.st == sct_pkg::ST_EXEC) &&
                   (core_ff.opcode[7:3] == sct_pkg::G5_MOV_A_R)
                   |=> instr_done && (acc_value == $past(core_ff.wreg[core_ff.opcode[2:0]])))
    else $error("register copy to accumulator wrong or late");

  a_two_byte_len :
  assert property ((core_ff.st == sct_pkg::ST_EXEC) &&
                   (core_ff.opcode[7:3] == sct_pkg::G5_MOV_R_IMM)
                   |-> !instr_done [*4] ##1 instr_done)
    else $error("two-byte register load did not take two machine cycles");

  a_add_sum_carry :
  assert property ((core_ff.st == sct_pkg::ST_EXEC) &&
                   (core_ff.opcode[7:3] == sct_pkg::G5_ADD_R)
                   |=> {psw_value[sct_pkg::PSW_CY], acc_value} ==
                       ($past({1'b0, core_ff.acc}) + $past({1'b0, alu_b})))
    else $error("register add gave wrong sum or carry");

  a_nibble_xchg_high :
  assert property ((core_ff.st == sct_pkg::ST_EXEC) &&
                   (core_ff.opcode[7:1] == sct_pkg::G7_NIBBLE_EXCHANGE_INDIRECT_M)
                   |-> ram_we && (ram_wdata[7:4] == dmem_bus.rdata[7:4])
                   ##1 $stable(acc_value[7:4]))
    else $error("nibble exchange disturbed an upper nibble");

  a_psw_load :
  assert property ((core_ff.st == sct_pkg::ST_EXEC) &&
                   (core_ff.opcode == sct_pkg::OP_WR_PSW)
                   |=> psw_value == $past(acc_value))
    else $error("status word load did not copy the accumulator");

  a_host_status_copy :
  assert property ((core_ff.st == sct_pkg::ST_EXEC) &&
                   (core_ff.opcode == sct_pkg::OP_WR_STS)
                   |=> host_status_hi == acc_value[7:4])
    else $error("host status nibble not loaded");

  a_carry_invert :
  assert property ((core_ff.st == sct_pkg::ST_EXEC) &&
                   (core_ff.opcode == sct_pkg::OP_CPL_C)
                   |=> $changed(psw_value[sct_pkg::PSW_CY]) && $stable(acc_value))
    else $error("carry invert did not toggle the carry");

  a_acc_increment :
  assert property ((core_ff.st == sct_pkg::ST_EXEC) &&
                   (core_ff.opcode == sct_pkg::OP_INC_A)
                   |=> acc_value == ($past(acc_value) + 8'h01))
    else $error("accumulator increment wrong");

  a_quiet_opcode :
  assert property ((core_ff.st == sct_pkg::ST_EXEC) &&
                   (core_ff.opcode == sct_pkg::OP_NOP)
                   |=> instr_done && $stable(acc_value) && $stable(psw_value))
    else $error("no-effect opcode changed state");

  c_table_read : cover property ((core_ff.st == sct_pkg::ST_EXEC2) &&
                                 (core_ff.opcode == sct_pkg::OP_TBL_PG3));
  c_add_overflow : cover property (retire && (alu_op == sct_pkg::ALU_ADD_WITH_CARRY) && alu_cy);
  c_mem_exchange : cover property (retire && (core_ff.opcode[7:1] == sct_pkg::G7_XCH_M));
endmodule // sct_core
`default_nettype wire

// ===== dv/sct_rom_model.sv
// Program memory model facing the core: synchronous read, one clock of latency.
// Assumes the bench fills mem through the instance before each fetch.
`timescale 1ns/10ps
`default_nettype none
module sct_rom_model #(
  parameter int AW = 11
) (
  input wire logic core_clk,
  input wire logic [AW-1:0] addr,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:(1<<AW)-1];

  // Registered read, so the core must wait one edge for its byte
  always_ff @(posedge core_clk) begin
    rdata <= mem[addr];
  end
endmodule // sct_rom_model
`default_nettype wire

// ===== dv/sct_core_tb.sv
// Self-checking bench of the slave core: programs are written into the ROM model
// one instruction ahead of the fetch. Assumes the core retires with instr_done.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module sct_core_tb;
  localparam logic [7:0] OPS [0:41] = '{8'h23, 8'hF8, 8'hA8, 8'hB8, 8'h28, 8'hF0,
    8'hA0, 8'hB0, 8'hA3, 8'hE3, 8'h20, 8'h30, 8'hC7, 8'hD7, 8'h90, 8'h97, 8'hA7,
    8'h85, 8'h95, 8'hA5, 8'hB5, 8'h03, 8'h68, 8'h60, 8'h13, 8'h78, 8'h70, 8'h53,
    8'h58, 8'h50, 8'h43, 8'h48, 8'h40, 8'hD3, 8'hD8, 8'hD0, 8'h17, 8'h07, 8'h80,
    8'hC0, 8'hE0, 8'h66};
  localparam logic [15:0] CORNER [0:14] = '{16'h23FF, 16'h0301, 16'h13FF, 16'h0700,
    16'h1700, 16'h23FF, 16'hD700, 16'hC700, 16'h9000, 16'h8000, 16'hA700, 16'hB500,
    16'h2388, 16'h0388, 16'h0000};
  logic core_clk, rst_n, user_flag_one, instr_done, f1;
  logic [10:0] prog_addr, pc;
  logic [7:0] prog_data, acc_value, psw_value, acc, program_status_word;
  logic [3:0] host_status_hi, sts;
  logic [7:0] rf [0:7];
  logic [7:0] dm [0:255];
  logic [31:0] seed;
  int fail_count, checks_done;

  sct_core sct_core_inst (.core_clk(core_clk), .rst_n(rst_n), .prog_addr(prog_addr),
    .prog_data(prog_data), .acc_value(acc_value), .psw_value(psw_value),
    .user_flag_one(user_flag_one), .host_status_hi(host_status_hi),
    .instr_done(instr_done));
  sct_rom_model sct_rom_model_inst (.core_clk(core_clk), .addr(prog_addr),
    .rdata(prog_data));

  // Free-running core clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Two-cycle opcodes; table reads are one byte but still two cycles
  function automatic int cycles(input logic [7:0] op);
    if (op inside {8'h23, 8'hA3, 8'hE3, 8'h03, 8'h13, 8'h53, 8'h43, 8'hD3}) return 2;
    if (op[7:3] == 5'h17 || op[7:1] == 7'h58) return 2;
    return 1;
  endfunction

  // Reference effect of one instruction on the bench's copy of the state
  task automatic model(input logic [7:0] op, input logic [7:0] n);
    logic [7:0] r, b, t;
    logic [8:0] s;
    logic ci;
    r = rf[op[2:0]];
    t = rf[{2'b00, op[0]}];
    b = (op[3:0] == 4'h3) ? n : (op[3] ? r : dm[t]);
    ci = op[4] & program_status_word[7];
    casez (op)
      8'h23, 8'hA3, 8'hE3: acc = n;
      8'b1111_1???: acc = r;
      8'b1010_1???: rf[op[2:0]] = acc;
      8'b1011_1???: rf[op[2:0]] = n;
      8'b0010_1???: begin
        rf[op[2:0]] = acc;
        acc = r;
      end
      8'b1111_000?: acc = dm[t];
      8'b1010_000?: dm[t] = acc;
      8'b1011_000?: dm[t] = n;
      8'b0010_000?: begin
        dm[t] = acc;
        acc = b;
      end
      8'b0011_000?: begin
        dm[t] = {b[7:4], acc[3:0]};
        acc = {acc[7:4], b[3:0]};
      end
      8'hC7: acc = program_status_word;
      8'hD7: program_status_word = acc;
      8'h90: sts = acc[7:4];
      8'h97: program_status_word[7] = 1'b0;
      8'hA7: program_status_word[7] = ~program_status_word[7];
      8'h85: program_status_word[5] = 1'b0;
      8'h95: program_status_word[5] = ~program_status_word[5];
      8'hA5: f1 = 1'b0;
      8'hB5: f1 = ~f1;
      8'h03, 8'b0110_1???, 8'b0110_000?, 8'h13, 8'b0111_1???, 8'b0111_000?: begin
        s = acc + b + ci;
        program_status_word[6] = (acc[3:0] + b[3:0] + ci) > 15;
        program_status_word[7] = s[8];
        acc = s[7:0];
      end
      8'h53, 8'b0101_1???, 8'b0101_000?: acc = acc & b;
      8'h43, 8'b0100_1???, 8'b0100_000?: acc = acc | b;
      8'hD3, 8'b1101_1???, 8'b1101_000?: acc = acc ^ b;
      8'h17: acc = acc + 8'h01;
      8'h07: acc = acc - 8'h01;
      default: ;
    endcase
  endtask

  // Place one instruction at the fetch address, wait for it to retire, compare
  task automatic step(input logic [7:0] op, input logic [7:0] n);
    int k;
    logic [10:0] pc1, ta;
    pc1 = pc + 11'h001;
    ta = op[6] ? {3'h3, acc} : {pc1[10:8], acc};
    sct_rom_model_inst.mem[pc] = op;
    sct_rom_model_inst.mem[pc1] = n;
    // A table read whose lookup hits its own opcode must see that opcode
    if (ta != pc && (op == 8'hA3 || op == 8'hE3)) sct_rom_model_inst.mem[ta] = n;
    model(op, (op == 8'hA3 || op == 8'hE3) ? sct_rom_model_inst.mem[ta] : n);
    pc = pc + ((cycles(op) == 2 && op != 8'hA3 && op != 8'hE3) ? 11'h002 : 11'h001);
    k = 0;
    do begin
      @(negedge core_clk);
      k++;
    end while (instr_done !== 1'b1 && k < 12);
    // Also the first step after reset, so a hang there is counted too
    `CHK(k, 3 * cycles(op))
    `CHK(acc_value, acc)
    `CHK(psw_value, program_status_word)
    `CHK(user_flag_one, f1)
    `CHK(host_status_hi, sts)
    `CHK(prog_addr, pc)
  endtask

  task automatic rstep();
    logic [31:0] v;
    logic [7:0] op;
    v = rnd();
    op = OPS[v[15:0] % 16'd42];
    if (op[3:0] == 4'h8) op[2:0] = v[18:16];
    else if (op[3:0] == 4'h0 && !(op inside {8'h80, 8'hC0, 8'hE0})) op[0] = v[16];
    step(op, v[31:24]);
  endtask

  // Reset for four cycles; working registers clear, data memory keeps its contents
  task automatic do_reset();
    rst_n = 1'b0;
    // Count rising edges so the start-up fall of the clock does not shorten reset
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    acc = 8'h00;
    program_status_word = 8'h00;
    f1 = 1'b0;
    sts = 4'h0;
    pc = 11'h000;
    foreach (rf[i]) rf[i] = 8'h00;
    `CHK(acc_value, 8'h00)
    `CHK(psw_value, 8'h00)
    `CHK(prog_addr, 11'h000)
    `CHK(instr_done, 1'b0)
    rst_n = 1'b1;
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // A hang is cut off well past the expected few thousand cycles
  initial begin
    repeat (30000) @(posedge core_clk);
    fail_count++;
    end_of_test();
  end

  initial begin
    logic [31:0] v;
    seed = 32'h0000_0020;
    fail_count = 0;
    checks_done = 0;
    rst_n = 1'b0;
    foreach (sct_rom_model_inst.mem[i]) sct_rom_model_inst.mem[i] = 8'h00;
    do_reset();
    // Every data byte is written first so indirect reads never see unknowns
    for (int i = 0; i < 256; i++) begin
      v = rnd();
      step(8'hB8, i[7:0]);
      step(8'hB0, v[7:0]);
    end
    $display("test fill done, %0d checks", checks_done);
    foreach (CORNER[i]) step(CORNER[i][15:8], CORNER[i][7:0]);
    $display("test corners done, %0d checks", checks_done);
    repeat (400) rstep();
    $display("test random done, %0d checks", checks_done);
    do_reset();
    repeat (30) rstep();
    $display("test second reset done, %0d checks", checks_done);
    end_of_test();
  end
endmodule // sct_core_tb
`default_nettype wire
